/* File: cot_pwm_pkg.sv */
package cot_pwm_pkg;

  // Time base
  localparam int CLK_PERIOD_NS = 8;

  // Counter widths
  localparam int ON_W = 11;
  localparam int K_W = 10;
  localparam int MIN_OFF_W = 6;
  localparam int DEAD_W = 4;
  localparam int OSC_W = 13;
  localparam int RATIO_W_DEF = 10;

  // Minimum off-time, least time so rounded up
  localparam int MIN_OFF_NS = 300;
  localparam logic [MIN_OFF_W-1:0] MIN_OFF_CYC =
    MIN_OFF_W'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Dead times, least times so rounded up
  localparam int DEAD_LO_NS = 30;
  localparam int DEAD_HI_NS = 40;
  localparam logic [DEAD_W-1:0] DEAD_LO_CYC =
    DEAD_W'((DEAD_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DEAD_W-1:0] DEAD_HI_CYC =
    DEAD_W'((DEAD_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // On-time factor K per strap level and channel
  localparam int K1_GND_NS = 5000;
  localparam int K2_GND_NS = 4000;
  localparam int K1_REF_NS = 3330;
  localparam int K2_REF_NS = 2670;
  localparam int K1_REG_NS = 2500;
  localparam int K2_REG_NS = 2000;
  localparam logic [K_W-1:0] K1_GND_CYC = K_W'(K1_GND_NS / CLK_PERIOD_NS);
  localparam logic [K_W-1:0] K2_GND_CYC = K_W'(K2_GND_NS / CLK_PERIOD_NS);
  localparam logic [K_W-1:0] K1_REF_CYC = K_W'(K1_REF_NS / CLK_PERIOD_NS);
  localparam logic [K_W-1:0] K2_REF_CYC = K_W'(K2_REF_NS / CLK_PERIOD_NS);
  localparam logic [K_W-1:0] K1_REG_CYC = K_W'(K1_REG_NS / CLK_PERIOD_NS);
  localparam logic [K_W-1:0] K2_REG_CYC = K_W'(K2_REG_NS / CLK_PERIOD_NS);

  // Nominal switching frequencies
  localparam int F1_GND_KHZ = 200;
  localparam int F2_GND_KHZ = 250;
  localparam int F1_REF_KHZ = 300;
  localparam int F2_REF_KHZ = 375;
  localparam int F1_REG_KHZ = 400;
  localparam int F2_REG_KHZ = 500;

  // Ultrasonic oscillator, period kept under the 25kHz limit
  localparam int USON_MAX_PERIOD_NS = 40000;
  localparam int USON_PERIOD_NS = 37000;
  localparam int USON_PERIOD_CYC = USON_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    LVL_GND = 2'b00,
    LVL_REF = 2'b01,
    LVL_REG5 = 2'b10,
    LVL_REG3 = 2'b11
  } strap_level_e;

  typedef enum logic [1:0] {
    MODE_FCCM = 2'b00,
    MODE_DEM = 2'b01,
    MODE_USON = 2'b10
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEAD_HI = 3'b001,
    ST_ON = 3'b010,
    ST_DEAD_LO = 3'b011,
    ST_LOW = 3'b100
  } phase_e;

  typedef struct packed {
    logic error_high;
    logic over_limit;
    logic zero_cross;
    logic ch1_above_switchover;
  } cmp_s;

  typedef struct packed {
    logic high_side_drive;
    logic low_side_drive;
  } gate_s;

endpackage : cot_pwm_pkg

/* File: cycle_one_shot.sv */
module cycle_one_shot #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Trigger
  input wire logic load_i,
  input wire logic [W-1:0] len_i,
  // Status
  output logic busy_o,
  output logic expire_o
);

  logic [W-1:0] cnt_q;

  if (W < 1 || W > 16) begin : g_bad_width
    $error("cycle_one_shot: width out of range");
  end

  // A zero length never expires; callers clamp to at least one cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy_o = (cnt_q != '0);
  assign expire_o = (cnt_q == W'(1));

endmodule : cycle_one_shot

/* File: cot_buck_pwm_sequencer.sv */
module cot_buck_pwm_sequencer #(
  parameter bit CHANNEL = 1'b0,
  parameter int RATIO_W = cot_pwm_pkg::RATIO_W_DEF,
  parameter int USON_PERIOD_CYC = cot_pwm_pkg::USON_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Straps, caught once after reset
  input wire logic [1:0] freq_select_strap_i,
  input wire logic [1:0] mode_select_strap_i,
  // Comparators and voltage ratio
  input wire cot_pwm_pkg::cmp_s cmp_i,
  input wire logic [RATIO_W-1:0] ratio_i,
  // Switch drivers and supply select
  output cot_pwm_pkg::gate_s gate_o,
  output logic supply_from_channel_one_o
);
  import cot_pwm_pkg::*;

  function automatic bit k_freq_ok(input int k_ns, input int f_khz);
    return (k_ns * f_khz >= 990_000) && (k_ns * f_khz <= 1_010_000);
  endfunction : k_freq_ok

  if (!k_freq_ok(K1_GND_NS, F1_GND_KHZ) || !k_freq_ok(K2_GND_NS, F2_GND_KHZ) ||
      !k_freq_ok(K1_REF_NS, F1_REF_KHZ) || !k_freq_ok(K2_REF_NS, F2_REF_KHZ) ||
      !k_freq_ok(K1_REG_NS, F1_REG_KHZ) || !k_freq_ok(K2_REG_NS, F2_REG_KHZ))
  begin : g_bad_table
    $error("cot_buck_pwm_sequencer: K and frequency table disagree");
  end
  if (RATIO_W < 4 || RATIO_W > 16 || USON_PERIOD_CYC < 2 ||
      USON_PERIOD_CYC >= (1 << OSC_W) ||
      USON_PERIOD_CYC * CLK_PERIOD_NS >= USON_MAX_PERIOD_NS) begin : g_bad_param
    $error("cot_buck_pwm_sequencer: parameter out of range");
  end

  // factor per strap level and channel
  function automatic logic [K_W-1:0] k_cycles(input strap_level_e lvl, input bit ch2);
    logic [K_W-1:0] k;
    k = '0;
    unique case (lvl)
      LVL_GND: k = ch2 ? K2_GND_CYC : K1_GND_CYC;
      LVL_REF: k = ch2 ? K2_REF_CYC : K1_REF_CYC;
      LVL_REG5, LVL_REG3: k = ch2 ? K2_REG_CYC : K1_REG_CYC;
    endcase
    return k;
  endfunction : k_cycles

  // ratio is a fraction of full scale; clamped so a pulse always ends
  function automatic logic [ON_W-1:0] on_cycles(input logic [K_W-1:0] k,
                                               input logic [RATIO_W-1:0] r);
    logic [K_W+RATIO_W-1:0] prod;
    logic [ON_W-1:0] len;
    prod = k * r;
    len = ON_W'(prod >> RATIO_W);
    return (len == '0) ? ON_W'(1) : len;
  endfunction : on_cycles

  cmp_s sync1_q;
  cmp_s sync2_q;
  logic strap_taken_q;
  strap_level_e freq_q;
  mode_e mode_q;
  phase_e state_q;
  phase_e state_d;
  logic hold_q;
  logic hold_d;
  gate_s gate_q;
  logic supply_q;
  logic [OSC_W-1:0] osc_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= cmp_i;
      sync2_q <= sync1_q;
    end
  end

  wire err_s = sync2_q.error_high;
  wire lim_s = sync2_q.over_limit;
  wire zc_s = sync2_q.zero_cross;
  wire sw_s = sync2_q.ch1_above_switchover;

  wire strap_level_e mode_lvl = strap_level_e'(mode_select_strap_i);
  wire mode_e mode_d = (mode_lvl == LVL_GND) ? MODE_FCCM :
                       (mode_lvl == LVL_REF) ? MODE_DEM : MODE_USON;

  // Straps are read once so a glitch cannot change mode mid-run
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_taken_q <= 1'b0;
      freq_q <= LVL_GND;
      mode_q <= MODE_FCCM;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      freq_q <= strap_level_e'(freq_select_strap_i);
      mode_q <= mode_d;
    end
  end

  // channel picks its own K set; the other channel has its own instance
  wire [K_W-1:0] k_sel = k_cycles(freq_q, CHANNEL);
  // on-time does not depend on mode or load
  wire [ON_W-1:0] on_len = on_cycles(k_sel, ratio_i);

  wire enter_on = (state_d == ST_ON) && (state_q != ST_ON);
  // minimum off-time starts as the high side turns off
  wire min_off_load = (state_q == ST_ON) && (state_d == ST_DEAD_LO);
  wire dead_load = (state_d != state_q) &&
                   ((state_d == ST_DEAD_HI) || (state_d == ST_DEAD_LO));
  wire [DEAD_W-1:0] dead_len = (state_d == ST_DEAD_HI) ? DEAD_HI_CYC : DEAD_LO_CYC;
  wire on_expire;
  wire min_off_busy;
  wire dead_expire;
  wire uson = (mode_q == MODE_USON);

  cycle_one_shot #(.W(ON_W)) u_on_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(enter_on),
    .len_i(on_len),
    .busy_o(),
    .expire_o(on_expire)
  );

  cycle_one_shot #(.W(MIN_OFF_W)) u_min_off_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(min_off_load),
    .len_i(MIN_OFF_CYC),
    .busy_o(min_off_busy),
    .expire_o()
  );

  cycle_one_shot #(.W(DEAD_W)) u_dead_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(dead_load),
    .len_i(dead_len),
    .busy_o(),
    .expire_o(dead_expire)
  );

  // oscillator restarts on every high-side pulse, so it fires only after a full period without one
  wire osc_tick = uson && (osc_q == OSC_W'(USON_PERIOD_CYC - 1));
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || enter_on || osc_tick) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_q + OSC_W'(1);
    end
  end

  // start condition; no start while over the limit
  wire start_ok = strap_taken_q && err_s && !lim_s && !min_off_busy;

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start_ok) begin
          state_d = ST_DEAD_HI;
        // oscillator forces the low side on
        end else if (osc_tick) begin
          state_d = ST_LOW;
          hold_d = 1'b1;
        end
      end
      ST_DEAD_HI: begin
        // limit still high when the dead time expires cancels the pulse
        if (dead_expire) begin
          state_d = lim_s ? ST_DEAD_LO : ST_ON;
        end
      end
      ST_ON: begin
        if (on_expire) begin
          state_d = ST_DEAD_LO;
        end
      end
      ST_DEAD_LO: begin
        if (dead_expire) begin
          state_d = ST_LOW;
        end
      end
      ST_LOW: begin
        // restart as soon as allowed, so heavy load runs at preset frequency
        if (start_ok) begin
          state_d = ST_DEAD_HI;
        // zero crossing ends the low side; not in forced mode
        end else if (mode_q != MODE_FCCM && zc_s && !hold_q) begin
          state_d = ST_IDLE;
        end else if (osc_tick) begin
          hold_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        hold_d = 1'b0;
      end
    endcase
    // once the next high-side on-time starts the normal zero-crossing exit applies again
    if (state_d == ST_ON) begin
      hold_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      hold_q <= 1'b0;
      gate_q <= '0;
      supply_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      // drives follow the next phase so they come from flops
      gate_q.high_side_drive <= (state_d == ST_ON);
      gate_q.low_side_drive <= (state_d == ST_LOW);
      // supply switchover belongs to channel one only
      supply_q <= !CHANNEL && sw_s;
    end
  end

  assign gate_o = gate_q;
  assign supply_from_channel_one_o = supply_q;

  // Helpers for the checks below
  logic [ON_W-1:0] on_len_q;
  logic [ON_W-1:0] hs_run_q;
  logic [6:0] lo_run_q;
  logic [OSC_W-1:0] idle_run_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      on_len_q <= '0;
      hs_run_q <= '0;
      lo_run_q <= '1;
      idle_run_q <= '0;
    end else begin
      if (enter_on) begin
        on_len_q <= on_len;
      end
      hs_run_q <= gate_q.high_side_drive ? hs_run_q + ON_W'(1) : '0;
      if (gate_q.high_side_drive) begin
        lo_run_q <= '0;
      end else if (lo_run_q != '1) begin
        lo_run_q <= lo_run_q + 7'(1);
      end
      // Saturates so long idle stretches in other modes cannot wrap
      if (gate_q != '0) begin
        idle_run_q <= '0;
      end else if (idle_run_q != '1) begin
        idle_run_q <= idle_run_q + OSC_W'(1);
      end
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  a_no_overlap: assert property (
    !(gate_o.high_side_drive && gate_o.low_side_drive))
    else $error("both switches on");
  a_dead_after_high: assert property (
    $fell(gate_o.high_side_drive) |-> !gate_o.low_side_drive [*4])
    else $error("low side on inside dead time");
  a_on_time_length: assert property (
    $fell(gate_o.high_side_drive) |-> $past(hs_run_q) == on_len_q - ON_W'(1))
    else $error("on-time length wrong");
  a_min_off_time: assert property (
    $rose(gate_o.high_side_drive) |-> $past(lo_run_q) >= 7'(MIN_OFF_CYC) - 7'(1))
    else $error("minimum off-time violated");
  a_start_gated: assert property (
    (state_q == ST_DEAD_HI && $past(state_q) != ST_DEAD_HI) |->
      $past(err_s) && !$past(min_off_busy))
    else $error("start without error high or before off-time");
  a_limit_blocks_high: assert property (
    $rose(gate_o.high_side_drive) |-> !$past(lim_s))
    else $error("high side on over current limit");
  a_dem_zero_cross: assert property (
    (mode_q == MODE_DEM && state_q == ST_LOW && zc_s && !start_ok) |=>
      !gate_o.low_side_drive)
    else $error("low side not released at zero crossing");
  a_fccm_returns: assert property (
    (mode_q == MODE_FCCM && $fell(gate_o.low_side_drive)) |->
      ##[1:10] (gate_o.high_side_drive || gate_o.low_side_drive))
    else $error("forced mode left both switches off");
  a_uson_osc_low: assert property (
    (osc_tick && state_q == ST_IDLE && !start_ok) |=> gate_o.low_side_drive)
    else $error("oscillator did not turn low side on");
  a_uson_hold_low: assert property (
    (hold_q && state_q == ST_LOW && !start_ok) |=> gate_o.low_side_drive)
    else $error("forced low side released early");
  a_supply_switch: assert property (
    $rose(sw_s) |=> supply_from_channel_one_o == !CHANNEL)
    else $error("supply switchover not followed");
  a_uson_min_freq: assert property (
    uson |-> idle_run_q <= OSC_W'(USON_PERIOD_CYC))
    else $error("ultrasonic idle gap too long");

  c_dem_pulse: cover property (mode_q == MODE_DEM && $rose(gate_o.high_side_drive));
  c_uson_osc: cover property (osc_tick && state_q == ST_IDLE);
  c_limit_abort: cover property (state_q == ST_DEAD_HI && dead_expire && lim_s);
  c_fccm_cycle: cover property (mode_q == MODE_FCCM && $fell(gate_o.high_side_drive));

endmodule : cot_buck_pwm_sequencer

/* File: gate_driver_model.sv */
module gate_driver_model (
  // Gate commands from the sequencer
  input wire cot_pwm_pkg::gate_s gate_i,
  // Power stage view
  output logic switch_node_o,
  output logic shoot_through_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cot_pwm_pkg::*;
  logic last_level;

  // both switches on shorts the input supply
  assign shoot_through_o = gate_i.high_side_drive & gate_i.low_side_drive;

  initial last_level = 1'b0;
  always @(gate_i) begin
    if (gate_i.high_side_drive) begin
      last_level = 1'b1;
    end else if (gate_i.low_side_drive) begin
      last_level = 1'b0;
    end
  end

  // Node floats with both switches off, so show the opposite of the last driven level
  assign switch_node_o = gate_i.high_side_drive ? 1'b1 :
                         gate_i.low_side_drive ? 1'b0 : ~last_level;
endmodule : gate_driver_model

/* File: cot_buck_pwm_sequencer_tb.sv */
module cot_buck_pwm_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cot_pwm_pkg::*;
  logic sys_clk;
  logic rst;
  logic [1:0] freq_sel;
  logic [1:0] mode_sel;
  cmp_s cmp;
  logic [RATIO_W_DEF-1:0] ratio;
  gate_s gate;
  logic supply_sel;
  logic node;
  logic shoot;
  gate_s gate2;
  logic supply_sel2;
  int h;
  localparam int USON_SIM = 200;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int g;

  cot_buck_pwm_sequencer #(.USON_PERIOD_CYC(USON_SIM)) i_cot_buck_pwm_sequencer (
    .sys_clk_i(sys_clk), .rst_i(rst), .freq_select_strap_i(freq_sel),
    .mode_select_strap_i(mode_sel), .cmp_i(cmp), .ratio_i(ratio), .gate_o(gate),
    .supply_from_channel_one_o(supply_sel));

  // Second channel shares every input, so its own K set shows directly
  cot_buck_pwm_sequencer #(.CHANNEL(1'b1), .USON_PERIOD_CYC(USON_SIM))
    i_cot_buck_pwm_sequencer_ch2 (
    .sys_clk_i(sys_clk), .rst_i(rst), .freq_select_strap_i(freq_sel),
    .mode_select_strap_i(mode_sel), .cmp_i(cmp), .ratio_i(ratio), .gate_o(gate2),
    .supply_from_channel_one_o(supply_sel2));

  gate_driver_model i_gate_driver_model (
    .gate_i(gate), .switch_node_o(node), .shoot_through_o(shoot));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (err_total == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard well above the longest expected run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  always @(negedge sys_clk) begin
    if (shoot === 1'b1) begin
      check(shoot, 0);
    end
  end

  task automatic do_reset(input logic [1:0] f, input logic [1:0] m);
    rst = 1'b1;
    freq_sel = f;
    mode_sel = m;
    cmp = '0;
    repeat (4) @(negedge sys_clk);
    check(gate, 0);
    rst = 1'b0;
  endtask : do_reset

  // Counts falling edges until the chosen gate reaches the level, bounded
  task automatic wait_gate(input bit hi, input logic lvl, output int k);
    k = 0;
    while ((hi ? gate.high_side_drive : gate.low_side_drive) !== lvl && k < 1000) begin
      @(negedge sys_clk);
      k++;
    end
  endtask : wait_gate

  task automatic run_forced();
    logic [K_W-1:0] kc [3];
    logic [K_W-1:0] kc2 [3];
    kc = '{K1_GND_CYC, K1_REF_CYC, K1_REG_CYC};
    kc2 = '{K2_GND_CYC, K2_REF_CYC, K2_REG_CYC};
    for (int i = 0; i < 3; i++) begin
      do_reset(2'(i), 2'h0);
      cmp.error_high = 1'b1;
      h = (32'(kc2[i]) * 32'(ratio)) >> RATIO_W_DEF;
      wait_gate(1, 1, n);
      check(node, 1);
      repeat (h - 1) @(negedge sys_clk);
      check(gate2.high_side_drive, 1);
      @(negedge sys_clk);
      check(gate2.high_side_drive, 0);
      wait_gate(1, 0, n);
      check(n + h, (32'(kc[i]) * 32'(ratio)) >> RATIO_W_DEF);
      check(node, 0);
      wait_gate(0, 1, g);
      check(g, 4);
      wait_gate(0, 0, n);
      g = g + n;
      wait_gate(1, 1, n);
      check(n, 5);
      g = g + n;
      check(g >= 43 && g <= 46, 1);
      cmp.error_high = 1'b0;
      cmp.zero_cross = 1'b1;
      wait_gate(1, 0, n);
      check(n, (32'(kc[i]) * 32'(ratio)) >> RATIO_W_DEF);
      repeat (60) @(negedge sys_clk);
      check(gate.low_side_drive, 1);
    end
  endtask : run_forced

  task automatic run_limit();
    do_reset(2'h2, 2'h0);
    cmp.over_limit = 1'b1;
    cmp.error_high = 1'b1;
    repeat (100) @(negedge sys_clk);
    check(gate.high_side_drive, 0);
    cmp.over_limit = 1'b0;
    wait_gate(1, 1, n);
    check(n <= 12, 1);
  endtask : run_limit

  task automatic run_dem();
    do_reset(2'h2, 2'h1);
    cmp.error_high = 1'b1;
    wait_gate(1, 1, n);
    cmp.error_high = 1'b0;
    wait_gate(1, 0, n);
    check(n, 32'(K1_REG_CYC) / 2);
    wait_gate(0, 1, n);
    repeat (10) @(negedge sys_clk);
    check(gate.low_side_drive, 1);
    cmp.zero_cross = 1'b1;
    wait_gate(0, 0, n);
    check(n <= 4, 1);
    repeat (100) @(negedge sys_clk);
    check(gate, 0);
  endtask : run_dem

  task automatic run_uson();
    do_reset(2'h2, 2'h2);
    wait_gate(0, 1, n);
    check(n <= 210, 1);
    cmp.zero_cross = 1'b1;
    repeat (20) @(negedge sys_clk);
    check(gate.low_side_drive, 1);
    cmp.error_high = 1'b1;
    wait_gate(0, 0, n);
    check(n <= 4, 1);
    wait_gate(1, 1, n);
    check(n, 5);
    cmp.error_high = 1'b0;
    wait_gate(1, 0, n);
    check(n, 32'(K1_REG_CYC) / 2);
    wait_gate(0, 1, n);
    check(n, 4);
    wait_gate(0, 0, n);
    check(n <= 4, 1);
    wait_gate(0, 1, n);
    check(n, USON_SIM - 32'(K1_REG_CYC) / 2 - 5);
  endtask : run_uson

  task automatic run_supply();
    cmp.ch1_above_switchover = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(supply_sel, 0);
    @(negedge sys_clk);
    check(supply_sel, 1);
    check(supply_sel2, 0);
  endtask : run_supply

  initial begin
    ratio = 10'h200;
    run_forced();
    run_limit();
    run_dem();
    run_uson();
    run_supply();
    report_and_stop();
  end
endmodule : cot_buck_pwm_sequencer_tb
